/* pia_defs.svh */
// Offsets, indices, reset values and timing counts of the parameter loader
`ifndef PIA_DEFS_SVH
`define PIA_DEFS_SVH

// ****************************************
// Timing
// ****************************************
`define PIA_CLK_NS        10
`define PIA_TICK_NS       100000000
`define PIA_TICK_CYC      (`PIA_TICK_NS / `PIA_CLK_NS)

// ****************************************
// Register offsets (byte addresses)
// ****************************************
`define PIA_OFS_SRC       8'h00
`define PIA_OFS_TGT       8'h04
`define PIA_OFS_SAVE      8'h08
`define PIA_OFS_PROT      8'h0C
`define PIA_OFS_CTRL      8'h10
`define PIA_OFS_STAT      8'h14
`define PIA_OFS_PAR       8'h40
`define PIA_OFS_PAR_END   8'h7C

// ****************************************
// Parameter table layout
// ****************************************
`define PIA_PAR_N         16
`define PIA_IX_COMM_LO    0
`define PIA_IX_COMM_HI    1
`define PIA_IX_ULOG_LO    2
`define PIA_IX_ULOG_HI    3
`define PIA_IX_RCAP       4
`define PIA_IX_MTYPE      5
`define PIA_IX_RCUR       6
`define PIA_IX_NLOAD      7
`define PIA_IX_ASD2       8
`define PIA_IX_POLE       9
`define PIA_IX_SYNC       10
`define PIA_IX_RSVD       11
`define PIA_IX_RLIM       12
`define PIA_IX_RIVL       13

// ****************************************
// Codes, ranges and factory values
// ****************************************
`define PIA_TGT_NONE      4'h0
`define PIA_TGT_ALL       4'h1
`define PIA_TGT_MOTOR     4'h2
`define PIA_TGT_NOCOMM    4'hB
`define PIA_TGT_ULOGIC    4'hC
`define PIA_RLIM_MAX      16'h0014
`define PIA_RIVL_MIN      16'h0005
`define PIA_RIVL_MAX      16'h00C8
`define PIA_MTYPE_PM      16'h0014
`define PIA_FAC_RCAP      16'h0025
`define PIA_FAC_RLIM      16'h0000
`define PIA_FAC_RIVL      16'h0005
`define PIA_FAC_OTHER     16'h0000

`endif

/* pia_pkg.sv */
// Types of the parameter loader and auto-reset sequencer
`include "pia_defs.svh"
package pia_pkg;

   typedef logic [`PIA_PAR_N-1:0][15:0] pia_tab_t;

   typedef enum logic [2:0] {
      AR_RUN   = 3'h0,
      AR_WAIT  = 3'h1,
      AR_RST   = 3'h3,
      AR_CHK   = 3'h2,
      AR_ALARM = 3'h6
   } pia_ar_t;

   typedef struct packed {
      logic       keys;
      logic       other;
      logic       nrun;
      logic [8:0] trip;
   } pia_pins_t;

   typedef struct packed {
      pia_pins_t  s1;
      pia_pins_t  s2;
      pia_pins_t  s3;
      pia_pins_t  pins;
      logic       src;
      logic [3:0] tgt;
      logic       prot;
      logic       saved;
      pia_tab_t   par;
      pia_tab_t   usr;
      pia_ar_t    ar;
      logic [4:0] cnt;
      logic [23:0] tick;
      logic [7:0] ivl;
      logic       alarm;
      logic       rcmd;
      logic       retry;
      logic [15:0] rdata;
   } pia_st_t;

endpackage

/* pia_param_init.sv */
// Parameter initialisation, user set save and auto-reset sequencer
//
// How it works
// (R1) Target 0: nothing changes
// (R2) Target 1: reload all from chosen source
// (R3) Target 2: motor parameters from capacity, type
// (R4) Target 11: all except communication entries
// (R5) Target 12: customizable-logic entries only
// (R6) Source 0: factory values everywhere
// (R7) Source 1: user set, else factory
// (R8) Target returns to 0 after init
// (R9) Key registers written only with two keys
// (R10) Save only if source 1, unprotected
// (R11) Repeated save overwrites stored set
// (R12) Operator protects set after saving
// (R13) Operator: type, capacity, then target 2
// (R14) Motor init rewrites rated and PM entries
// (R15) Capacity rounded to standard rating first
// (R16) Capacity write updates dependent entries
// (R17) Eligible trip retried without alarm
// (R18) Trips beyond limit raise alarm, stop
// (R19) Limit 0 disables, else 1 to 20
// (R20) Only listed trip causes are retried
// (R21) Wait 0.5 to 20.0 s before reset
// (R22) Normal run clears retry counter
`timescale 1ns/1ns
`include "pia_defs.svh"
module pia_param_init #(
   parameter int TICK_CYC = `PIA_TICK_CYC
) (
   input  wire logic        mclk_i,
   input  wire logic        rst_b_i,
   input  wire logic [7:0]  addr_i,
   input  wire logic [15:0] wdata_i,
   input  wire logic        wr_i,
   input  wire logic        rd_i,
   input  wire logic        keys_i,
   input  wire logic [8:0]  trip_i,
   input  wire logic        trip_other_i,
   input  wire logic        normal_run_i,
   output logic      [15:0] rd_data_o,
   output logic             alarm_o,
   output logic             reset_cmd_o,
   output logic             retrying_o
);

   // ****************************************
   // Helpers
   // ****************************************
   function automatic logic [15:0] fac_val(input int i);
      case (i)
         `PIA_IX_RCAP: fac_val = `PIA_FAC_RCAP;
         `PIA_IX_RLIM: fac_val = `PIA_FAC_RLIM;
         `PIA_IX_RIVL: fac_val = `PIA_FAC_RIVL;
         default:      fac_val = `PIA_FAC_OTHER;
      endcase
   endfunction

   // Ratings in 0.1 kW; odd values snap up, overlarge to the top
   function automatic logic [15:0] std_cap(input logic [15:0] c);
      if (c <= 16'h0004) begin
         std_cap = 16'h0004;
      end else if (c <= 16'h0007) begin
         std_cap = 16'h0007;
      end else if (c <= 16'h000F) begin
         std_cap = 16'h000F;
      end else if (c <= 16'h0016) begin
         std_cap = 16'h0016;
      end else if (c <= 16'h0025) begin
         std_cap = 16'h0025;
      end else if (c <= 16'h0037) begin
         std_cap = 16'h0037;
      end else if (c <= 16'h004B) begin
         std_cap = 16'h004B;
      end else begin
         std_cap = 16'h006E;
      end
   endfunction

   function automatic pia_pkg::pia_tab_t mderive(input pia_pkg::pia_tab_t p);
      logic [15:0] s;
      logic        pm;
      s  = std_cap(p[`PIA_IX_RCAP]);                                // R15
      pm = (p[`PIA_IX_MTYPE] >= `PIA_MTYPE_PM);
      mderive = p;
      mderive[`PIA_IX_RCUR]  = {s[14:0], 1'b0};                     // R14
      mderive[`PIA_IX_NLOAD] = {1'b0, s[15:1]};                     // R14
      mderive[`PIA_IX_ASD2]  = {2'b00, s[15:2]} + 16'h0001;         // R14
      mderive[`PIA_IX_POLE]  = {15'h0000, pm};                      // R14
      mderive[`PIA_IX_SYNC]  = pm ? s : 16'h0000;                   // R14
      mderive[`PIA_IX_RSVD]  = 16'h0000;                            // R14
   endfunction

   function automatic pia_pkg::pia_tab_t fac_tab();
      pia_pkg::pia_tab_t t;
      for (int i = 0; i < `PIA_PAR_N; i++) begin
         t[i] = fac_val(i);
      end
      fac_tab = mderive(t);
   endfunction

   function automatic pia_pkg::pia_st_t rst_st();
      pia_pkg::pia_st_t s;
      s     = '0;
      s.par = fac_tab();
      s.usr = fac_tab();
      s.ar  = pia_pkg::AR_RUN;
      rst_st = s;
   endfunction

   localparam pia_pkg::pia_st_t ST_RST = rst_st();
   localparam pia_pkg::pia_tab_t FAC   = fac_tab();

   // ****************************************
   // State
   // ****************************************
   pia_pkg::pia_st_t q;
   pia_pkg::pia_st_t d;
   pia_pkg::pia_pins_t pins_raw;
   pia_pkg::pia_tab_t  src_tab;
   logic [3:0] pidx;
   logic       in_par;
   logic       keys_ok;
   logic       trip_rs;
   logic [4:0] lim;

   assign pins_raw = '{keys: keys_i, other: trip_other_i,
                       nrun: normal_run_i, trip: trip_i};
   assign in_par  = (addr_i >= `PIA_OFS_PAR) && (addr_i <= `PIA_OFS_PAR_END);
   assign pidx    = addr_i[5:2];
   assign keys_ok = q.pins.keys;
   assign trip_rs = |q.pins.trip;                                   // R20
   assign lim     = q.par[`PIA_IX_RLIM][4:0];
   // Stored user set only counts once something was saved
   assign src_tab = (q.src && q.saved) ? q.usr : FAC;               // R6 R7

   always_comb begin
      d       = q;
      d.rcmd  = 1'b0;
      d.rdata = 16'h0000;

      // ****************************************
      // Pin synchronisers
      // ****************************************
      d.s1 = pins_raw;
      d.s2 = q.s1;
      d.s3 = q.s2;
      if (q.s2 == q.s3) begin
         d.pins = q.s3;
      end

      // ****************************************
      // Initialisation
      // ****************************************
      case (q.tgt)
         `PIA_TGT_ALL: begin
            d.par = mderive(src_tab);                               // R2
         end
         `PIA_TGT_MOTOR: begin
            d.par = mderive(q.par);                                 // R3
         end
         `PIA_TGT_NOCOMM: begin
            for (int i = 0; i < `PIA_PAR_N; i++) begin
               if (i > `PIA_IX_COMM_HI) begin
                  d.par[i] = src_tab[i];                            // R4
               end
            end
            d.par = mderive(d.par);
         end
         `PIA_TGT_ULOGIC: begin
            for (int i = `PIA_IX_ULOG_LO; i <= `PIA_IX_ULOG_HI; i++) begin
               d.par[i] = src_tab[i];                               // R5
            end
         end
         default: begin
            d.par = q.par;                                          // R1
         end
      endcase
      d.tgt = `PIA_TGT_NONE;                                        // R8

      // ****************************************
      // Register writes
      // ****************************************
      if (wr_i) begin
         if (in_par) begin
            d.par[pidx] = wdata_i;
            if (pidx == 4'(`PIA_IX_RLIM) && wdata_i > `PIA_RLIM_MAX) begin
               d.par[pidx] = `PIA_RLIM_MAX;                         // R19
            end
            if (pidx == 4'(`PIA_IX_RIVL)) begin
               if (wdata_i < `PIA_RIVL_MIN) begin
                  d.par[pidx] = `PIA_RIVL_MIN;                      // R21
               end else if (wdata_i > `PIA_RIVL_MAX) begin
                  d.par[pidx] = `PIA_RIVL_MAX;                      // R21
               end
            end
            if (pidx == 4'(`PIA_IX_RCAP)) begin
               d.par = mderive(d.par);                              // R16
            end
         end else if (keys_ok) begin                                // R9
            case (addr_i)
               `PIA_OFS_SRC: begin
                  d.src = wdata_i[0];
               end
               `PIA_OFS_PROT: begin
                  d.prot = wdata_i[0];
               end
               `PIA_OFS_TGT: begin
                  if (wdata_i[3:0] == `PIA_TGT_ALL ||
                      wdata_i[3:0] == `PIA_TGT_MOTOR ||
                      wdata_i[3:0] == `PIA_TGT_NOCOMM ||
                      wdata_i[3:0] == `PIA_TGT_ULOGIC) begin
                     d.tgt = wdata_i[3:0];
                  end
               end
               `PIA_OFS_SAVE: begin
                  if (wdata_i[0] && q.src && !q.prot) begin         // R10
                     d.usr   = q.par;                               // R11
                     d.saved = 1'b1;
                  end
               end
               default: begin
                  d.src = q.src;
               end
            endcase
         end
      end

      // ****************************************
      // Auto-reset sequencer
      // ****************************************
      case (q.ar)
         pia_pkg::AR_RUN, pia_pkg::AR_CHK: begin
            if (q.pins.other) begin
               d.ar = pia_pkg::AR_ALARM;
            end else if (trip_rs) begin
               if (lim == 5'h00 || q.cnt >= lim) begin              // R18 R19
                  d.ar = pia_pkg::AR_ALARM;
               end else begin
                  d.ar   = pia_pkg::AR_WAIT;                        // R17
                  d.tick = 24'h000000;
                  d.ivl  = 8'h00;
               end
            end else if (q.ar == pia_pkg::AR_CHK && q.pins.nrun) begin
               d.cnt = 5'h00;                                       // R22
               d.ar  = pia_pkg::AR_RUN;
            end
         end
         pia_pkg::AR_WAIT: begin
            if (q.pins.other) begin
               d.ar = pia_pkg::AR_ALARM;
            end else if (q.tick == 24'(TICK_CYC - 1)) begin
               d.tick = 24'h000000;
               d.ivl  = q.ivl + 8'h01;
               if (q.ivl == q.par[`PIA_IX_RIVL][7:0] - 8'h01) begin // R21
                  d.rcmd = 1'b1;                                    // R17
                  d.cnt  = q.cnt + 5'h01;
                  d.ar   = pia_pkg::AR_RST;
               end
            end else begin
               d.tick = q.tick + 24'h000001;
            end
         end
         pia_pkg::AR_RST: begin
            // Trip pin lags the reset command; wait for it to drop
            if (q.pins.other) begin
               d.ar = pia_pkg::AR_ALARM;
            end else if (!trip_rs) begin
               d.ar = pia_pkg::AR_CHK;
            end
         end
         pia_pkg::AR_ALARM: begin
            if (wr_i && addr_i == `PIA_OFS_CTRL && wdata_i[0]) begin
               d.ar  = pia_pkg::AR_RUN;
               d.cnt = 5'h00;
            end
         end
         default: begin
            d.ar = pia_pkg::AR_RUN;
         end
      endcase
      d.alarm = (d.ar == pia_pkg::AR_ALARM);                        // R18
      d.retry = (d.ar == pia_pkg::AR_WAIT) || (d.ar == pia_pkg::AR_RST);

      // ****************************************
      // Register reads
      // ****************************************
      if (rd_i) begin
         if (in_par) begin
            d.rdata = q.par[pidx];
         end else begin
            case (addr_i)
               `PIA_OFS_SRC:  d.rdata = {15'h0000, q.src};
               `PIA_OFS_TGT:  d.rdata = {12'h000, q.tgt};
               `PIA_OFS_PROT: d.rdata = {15'h0000, q.prot};
               `PIA_OFS_STAT: d.rdata = {5'h00, q.cnt, q.ar, q.alarm,
                                         q.retry, q.saved};
               default:       d.rdata = 16'h0000;
            endcase
         end
      end
   end

   always_ff @(posedge mclk_i or negedge rst_b_i) begin
      if (!rst_b_i) begin
         q <= ST_RST;
      end else begin
         q <= d;
      end
   end

   assign rd_data_o   = q.rdata;
   assign alarm_o     = q.alarm;
   assign reset_cmd_o = q.rcmd;
   assign retrying_o  = q.retry;

   // ****************************************
   // Assertions
   // ****************************************
   default clocking cb @(posedge mclk_i); endclocking
   default disable iff (!rst_b_i);

   AST_TGT_RETURN: assert property (q.tgt != 4'h0 |=> q.tgt == 4'h0) // R8
      else $error("init target did not return to zero");
   AST_TGT_IDLE: assert property (q.tgt == 4'h0 && !wr_i |=> q.par == $past(q.par)) // R1
      else $error("parameters changed without init or write");
   AST_COMM_KEPT: assert property (q.tgt == 4'hB && !wr_i |=>
      q.par[1:0] == $past(q.par[1:0])) // R4
      else $error("communication entries changed by limited init");
   AST_SAVE_OK: assert property (wr_i && addr_i == 8'h08 && wdata_i[0] && q.pins.keys
      && q.src && !q.prot |=> q.usr == $past(q.par) && q.saved) // R10
      else $error("user set not saved");
   AST_SAVE_BLOCK: assert property (wr_i && addr_i == 8'h08 && (q.prot || !q.src)
      |=> q.usr == $past(q.usr)) // R10
      else $error("user set saved while blocked");
   AST_KEY_GUARD: assert property (wr_i && addr_i == 8'h00 && !q.pins.keys
      |=> q.src == $past(q.src)) // R9
      else $error("source changed without two keys");
   AST_LIM_RANGE: assert property (q.par[12] <= 16'h0014) // R19
      else $error("retry limit out of range");
   AST_ZERO_LIM: assert property (q.ar == pia_pkg::AR_RUN && |q.pins.trip
      && q.par[12] == 16'h0000 |=> alarm_o) // R19
      else $error("no alarm with auto-reset disabled");
   AST_NO_ALM_WAIT: assert property (q.ar == pia_pkg::AR_WAIT |-> !alarm_o) // R17
      else $error("alarm during retry wait");
   AST_CNT_BOUND: assert property (reset_cmd_o |-> q.cnt <= q.par[12][4:0]) // R18
      else $error("reset issued beyond limit");
   AST_CNT_CLEAR: assert property (q.ar == pia_pkg::AR_CHK && q.pins.nrun
      && !(|q.pins.trip) && !q.pins.other |=> q.cnt == 5'h00) // R22
      else $error("retry count not cleared on normal run");
   AST_WAIT_LEN: assert property ($rose(q.ar == pia_pkg::AR_WAIT) |->
      !reset_cmd_o [*4]) // R21
      else $error("reset issued too early");

   COV_RETRY: cover property (reset_cmd_o);
   COV_ALARM: cover property ($rose(alarm_o));
   COV_MOTOR: cover property (q.tgt == 4'h2);
   COV_SAVE:  cover property ($rose(q.saved));

endmodule

/* pia_host.sv */
// Keypad or host model that sets and reads the drive parameters
`timescale 1ns/1ns
`include "pia_defs.svh"
module pia_host (
   input  wire logic        mclk_i,
   input  wire logic [15:0] rd_data_i,
   output logic      [7:0]  addr_o,
   output logic      [15:0] wdata_o,
   output logic             wr_o,
   output logic             rd_o,
   output logic             keys_o
);
   // ****************************************
   // Bus cycles
   // ****************************************
   initial begin
      addr_o = 8'h00;
      wdata_o = 16'h0000;
      wr_o = 1'b0;
      rd_o = 1'b0;
      keys_o = 1'b0;
   end

   task automatic wr(input logic [7:0] a, input logic [15:0] v);
      @(posedge mclk_i);
      addr_o <= a;
      wdata_o <= v;
      wr_o <= 1'b1;
      @(posedge mclk_i);
      wr_o <= 1'b0;
   endtask

   // Data stands only in the cycle after the strobe
   task automatic rd(input logic [7:0] a, output logic [15:0] d);
      @(posedge mclk_i);
      addr_o <= a;
      rd_o <= 1'b1;
      @(posedge mclk_i);
      rd_o <= 1'b0;
      @(negedge mclk_i);
      d = rd_data_i;
   endtask

   // ****************************************
   // Operator habits
   // ****************************************
   // Keys pass a slow synchroniser, so hold before use
   task automatic keys(input logic on);
      @(posedge mclk_i);
      keys_o <= on;
      repeat (6) @(posedge mclk_i);
   endtask

   task automatic motor_init(input logic [15:0] typ, input logic [15:0] cap);
      wr(`PIA_OFS_PAR + 8'h14, typ);
      wr(`PIA_OFS_PAR + 8'h10, cap);
      wr(`PIA_OFS_TGT, 16'h0002);
   endtask

   task automatic save_lock();
      wr(`PIA_OFS_SAVE, 16'h0001);
      wr(`PIA_OFS_PROT, 16'h0001);
   endtask
endmodule

/* testbench.sv */
// Self-checking bench of the parameter loader and auto-reset sequencer
`timescale 1ns/1ns
`include "pia_defs.svh"
module testbench;
   // Short tick keeps retry waits to a few cycles
   localparam int TICK = 4;
   logic        mclk;
   logic        rst_b;
   logic [7:0]  addr;
   logic [15:0] wdata;
   logic [15:0] rdat;
   logic        wr;
   logic        rd;
   logic        keys;
   logic [8:0]  trip;
   logic        trip_oth;
   logic        nrun;
   logic        alarm;
   logic        rcmd;
   logic        retrying;
   int          errors = 0;
   int          checks = 0;
   int          n_rcmd = 0;

   pia_param_init #(.TICK_CYC(TICK)) pia_param_init_i (
      .mclk_i(mclk), .rst_b_i(rst_b), .addr_i(addr), .wdata_i(wdata), .wr_i(wr),
      .rd_i(rd), .keys_i(keys), .trip_i(trip), .trip_other_i(trip_oth),
      .normal_run_i(nrun), .rd_data_o(rdat), .alarm_o(alarm), .reset_cmd_o(rcmd),
      .retrying_o(retrying));
   pia_host pia_host_i (
      .mclk_i(mclk), .rd_data_i(rdat), .addr_o(addr), .wdata_o(wdata), .wr_o(wr),
      .rd_o(rd), .keys_o(keys));

   // ****************************************
   // Helpers
   // ****************************************
   initial begin
      mclk = 1'b0;
      forever #5 mclk = ~mclk;
   end
   always @(posedge mclk) if (rcmd === 1'b1) n_rcmd <= n_rcmd + 1;

   task automatic end_sim();
      $display("checks=%0d errors=%0d", checks, errors);
      if (errors == 0 && checks > 0) $display("SIMULATION PASSED");
      else $display("SIMULATION FAILED");
      $finish;
   endtask

   task automatic chk(input string nm, input logic [15:0] e, input logic [15:0] g);
      checks++;
      if (g !== e) begin
         $display("[FAIL] %s expected %h seen %h", nm, e, g);
         errors++;
      end
   endtask

   function automatic logic [7:0] pa(input int i);
      pa = `PIA_OFS_PAR + 8'(4 * i);
   endfunction

   // Factory rating is standard, so dependents follow it directly
   function automatic logic [15:0] fac(input int i);
      case (i)
         `PIA_IX_RCAP:  fac = `PIA_FAC_RCAP;
         `PIA_IX_RLIM:  fac = `PIA_FAC_RLIM;
         `PIA_IX_RIVL:  fac = `PIA_FAC_RIVL;
         `PIA_IX_RCUR:  fac = `PIA_FAC_RCAP << 1;
         `PIA_IX_NLOAD: fac = `PIA_FAC_RCAP >> 1;
         `PIA_IX_ASD2:  fac = (`PIA_FAC_RCAP >> 2) + 16'h0001;
         default:       fac = `PIA_FAC_OTHER;
      endcase
   endfunction

   task automatic w(input logic [7:0] a, input logic [15:0] v);
      pia_host_i.wr(a, v);
   endtask

   task automatic rc(input string nm, input logic [7:0] a, input logic [15:0] e);
      logic [15:0] d;
      pia_host_i.rd(a, d);
      chk(nm, e, d);
   endtask

   task automatic all_fac();
      for (int i = 0; i < `PIA_PAR_N; i++) rc("par", pa(i), fac(i));
   endtask

   // Trip with cause k, then wait bounded for a reset command or the alarm
   task automatic trip_try(input int k, input logic exp_r);
      int n;
      n = 0;
      @(posedge mclk);
      trip <= 9'h001 << k;
      while (rcmd !== 1'b1 && alarm !== 1'b1 && n < 60) begin
         @(negedge mclk);
         n++;
      end
      chk("reset_cmd", {15'h0000, exp_r}, {15'h0000, rcmd});
      chk("alarm", {15'h0000, !exp_r}, {15'h0000, alarm});
      if (exp_r) begin
         chk("retrying", 16'h0001, {15'h0000, retrying});
         chk("wait_ok", 16'h0001, {15'h0000, n >= 20 && n <= 27});
      end else begin
         chk("retrying", 16'h0000, {15'h0000, retrying});
      end
      @(posedge mclk);
      trip <= 9'h000;
      repeat (6) @(posedge mclk);
   endtask

   task automatic clr_alarm();
      w(`PIA_OFS_CTRL, 16'h0001);
      repeat (2) @(posedge mclk);
      chk("alarm_clr", 16'h0000, {15'h0000, alarm});
   endtask

   // ****************************************
   // Scenarios
   // ****************************************
   task automatic s_keys();
      w(`PIA_OFS_SRC, 16'h0001);
      rc("src_nokey", `PIA_OFS_SRC, 16'h0000);
      w(pa(0), 16'h1234);
      w(`PIA_OFS_TGT, 16'h0001);
      rc("par0_nokey", pa(0), 16'h1234);
   endtask

   task automatic s_init();
      pia_host_i.keys(1'b1);
      for (int i = 0; i < 4; i++) w(pa(i), 16'h00A0 + 16'(i));
      w(pa(12), 16'h0003);
      w(`PIA_OFS_TGT, `PIA_TGT_NOCOMM);
      rc("tgt", `PIA_OFS_TGT, 16'h0000);
      rc("comm0", pa(0), 16'h00A0);
      rc("comm1", pa(1), 16'h00A1);
      rc("ulog2", pa(2), 16'h0000);
      rc("rlim", pa(12), `PIA_FAC_RLIM);
      w(pa(2), 16'h00A2);
      w(pa(12), 16'h0003);
      w(`PIA_OFS_TGT, `PIA_TGT_ULOGIC);
      rc("ulog2", pa(2), 16'h0000);
      rc("comm0", pa(0), 16'h00A0);
      rc("rlim", pa(12), 16'h0003);
      w(`PIA_OFS_TGT, `PIA_TGT_NONE);
      rc("rlim", pa(12), 16'h0003);
      w(`PIA_OFS_TGT, `PIA_TGT_ALL);
      all_fac();
   endtask

   task automatic s_save();
      logic [15:0] d;
      w(`PIA_OFS_SRC, 16'h0001);
      rc("src_key", `PIA_OFS_SRC, 16'h0001);
      w(pa(2), 16'h0055);
      w(`PIA_OFS_TGT, `PIA_TGT_ALL);
      rc("fallback", pa(2), 16'h0000);
      w(`PIA_OFS_SRC, 16'h0000);
      w(`PIA_OFS_SAVE, 16'h0001);
      pia_host_i.rd(`PIA_OFS_STAT, d);
      chk("saved_src0", 16'h0000, d & 16'h0001);
      w(`PIA_OFS_SRC, 16'h0001);
      w(pa(2), 16'h00AA);
      w(`PIA_OFS_SAVE, 16'h0001);
      pia_host_i.rd(`PIA_OFS_STAT, d);
      chk("saved", 16'h0001, d & 16'h0001);
      w(pa(2), 16'h00BB);
      pia_host_i.save_lock();
      w(pa(2), 16'h00CC);
      w(`PIA_OFS_SAVE, 16'h0001);
      w(pa(2), 16'h00DD);
      w(`PIA_OFS_TGT, `PIA_TGT_ALL);
      rc("user_set", pa(2), 16'h00BB);
   endtask

   // Rating 3.7 kW is standard: current 2x, no-load half, delay quarter plus one
   task automatic s_motor();
      pia_host_i.motor_init(`PIA_MTYPE_PM, 16'h0025);
      rc("rcur", pa(6), 16'h004A);
      rc("nload", pa(7), 16'h0012);
      rc("asd2", pa(8), 16'h000A);
      w(pa(6), 16'h0000);
      w(pa(8), 16'h0000);
      w(pa(9), 16'h0000);
      w(pa(0), 16'h0077);
      w(`PIA_OFS_TGT, `PIA_TGT_MOTOR);
      rc("rcur", pa(6), 16'h004A);
      rc("asd2", pa(8), 16'h000A);
      rc("pole", pa(9), 16'h0001);
      rc("comm0", pa(0), 16'h0077);
      w(pa(4), 16'h0020);
      w(`PIA_OFS_TGT, `PIA_TGT_MOTOR);
      rc("rcur_std", pa(6), 16'h004A);
      rc("sync", pa(10), 16'h0025);
   endtask

   task automatic s_retry();
      logic [15:0] d;
      w(pa(12), 16'h0015);
      rc("rlim_clamp", pa(12), `PIA_RLIM_MAX);
      w(pa(13), 16'h0001);
      rc("rivl_clamp", pa(13), `PIA_RIVL_MIN);
      for (int k = 0; k < 9; k++) trip_try(k, 1'b1);
      @(posedge mclk);
      nrun <= 1'b1;
      repeat (6) @(posedge mclk);
      nrun <= 1'b0;
      pia_host_i.rd(`PIA_OFS_STAT, d);
      chk("cnt", 16'h0000, {11'h000, d[10:6]});
      w(pa(12), 16'h0002);
      trip_try(0, 1'b1);
      trip_try(1, 1'b1);
      trip_try(2, 1'b0);
      chk("n_reset", 16'h000B, 16'(n_rcmd));
      clr_alarm();
      @(posedge mclk);
      trip_oth <= 1'b1;
      repeat (8) @(posedge mclk);
      trip_oth <= 1'b0;
      // Let the drop pass the synchroniser, else the clear re-alarms
      repeat (6) @(posedge mclk);
      chk("alarm_other", 16'h0001, {15'h0000, alarm});
      clr_alarm();
      w(pa(12), 16'h0000);
      trip_try(3, 1'b0);
      chk("n_reset", 16'h000B, 16'(n_rcmd));
   endtask

   // ****************************************
   // Main sequence and watchdog
   // ****************************************
   initial begin
      rst_b = 1'b0;
      trip = 9'h000;
      trip_oth = 1'b0;
      nrun = 1'b0;
      repeat (6) @(posedge mclk);
      rst_b <= 1'b1;
      @(posedge mclk);
      chk("alarm_rst", 16'h0000, {15'h0000, alarm});
      rc("stat_rst", `PIA_OFS_STAT, 16'h0000);
      rc("tgt_rst", `PIA_OFS_TGT, 16'h0000);
      all_fac();
      s_keys();
      s_init();
      s_save();
      s_motor();
      s_retry();
      end_sim();
   end

   // Whole run is under a thousand cycles
   initial begin
      repeat (20000) @(posedge mclk);
      errors++;
      end_sim();
   end
endmodule
